// >>> rtl/cpu_ls_pkg.sv
// shared constants and types for the load/store and misc execution unit
package cpu_ls_pkg;

  // register file shape and special indices
  localparam int unsigned NUM_GPR = 15;
  localparam logic [3:0] REG_SP = 4'hd;
  localparam logic [3:0] REG_LR = 4'he;
  localparam logic [3:0] REG_PC = 4'hf;

  // reset values
  localparam logic [31:0] GPR_RST = 32'h0000_0000;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic PRIMASK_RST = 1'b0;

  // address arithmetic
  localparam logic [31:0] HALF_INSN = 32'h0000_0002;
  localparam logic [31:0] LONG_INSN = 32'h0000_0004;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] WORD_MASK = 32'hffff_fffc;
  localparam logic [31:0] ISA_BIT = 32'h0000_0001;
  localparam logic [31:0] ISA_BIT_CLR = 32'hffff_fffe;

  // byte enables and flag positions
  localparam logic [3:0] BE_WORD = 4'hf;
  localparam logic [3:0] BE_LOW_HALF = 4'h3;
  localparam logic [3:0] BE_HIGH_HALF = 4'hc;
  localparam logic [3:0] BE_BYTE0 = 4'h1;
  localparam logic [3:0] FLAG_WE_ALL = 4'hf;
  localparam logic [3:0] FLAG_WE_NZ = 4'hc;
  localparam int unsigned FLAG_MSB = 31;
  localparam int unsigned FLAG_LSB = 28;

  typedef enum logic [4:0] {
    load_word, load_half, load_byte, load_signed_byte, load_signed_half,
    load_literal, store_word, store_half, store_byte,
    store_multiple_inc_after, stack_push, stack_pop,
    write_special_from_general, read_special_to_general, and_test_flags,
    zero_extend_byte, zero_extend_half, indirect_branch,
    indirect_branch_link, branch_link, wait_for_event_op, no_op
  } opc_t;

  typedef enum logic [1:0] {spec_apsr, spec_primask, spec_msp} spec_t;

  typedef enum logic [1:0] {sz_byte, sz_half, sz_word} size_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_t;

  typedef struct packed {
    opc_t opc;
    logic [3:0] rd;
    logic [3:0] rn;
    logic [3:0] rm;
    logic use_imm;
    logic long_insn;
    logic [31:0] imm;
    logic [15:0] reglist;
    spec_t spec;
  } op_t;

endpackage

// >>> rtl/mem_lane_unit.sv
// byte-lane steering, alignment check and load extension
`timescale 1ns/1ps
module mem_lane_unit
  import cpu_ls_pkg::*;
(
  input wire logic [31:0] addr,
  input wire size_t size,
  input wire logic sign_ext,
  input wire logic [31:0] store_val,
  input wire logic [31:0] load_word,
  output logic aligned,
  output logic [3:0] byte_en,
  output logic [31:0] lane_wdata,
  output logic [31:0] load_val
);

  logic [31:0] shifted;

  // little-endian lane select from the low address bits
  always_comb begin
    shifted = load_word >> {addr[1:0], 3'b000};
    case (size)
      sz_byte: begin
        aligned = 1'b1;
        byte_en = BE_BYTE0 << addr[1:0];
        lane_wdata = {4{store_val[7:0]}};
        load_val = sign_ext ? {{24{shifted[7]}}, shifted[7:0]} // RULE1
                            : {24'h000000, shifted[7:0]};
      end
      sz_half: begin
        aligned = !addr[0]; // RULE15
        byte_en = addr[1] ? BE_HIGH_HALF : BE_LOW_HALF;
        lane_wdata = {2{store_val[15:0]}};
        load_val = sign_ext ? {{16{shifted[15]}}, shifted[15:0]} // RULE1
                            : {16'h0000, shifted[15:0]};
      end
      default: begin
        aligned = addr[1:0] == 2'b00; // RULE15
        byte_en = BE_WORD;
        lane_wdata = store_val;
        load_val = load_word;
      end
    endcase
  end

endmodule

// >>> rtl/cpu_ls_exec.sv
// load/store, stack, special-move, test and branch-link execution unit
//
// Contract
// [RULE1] Word, halfword and byte loads, plus sign-extending halfword and byte loads, leave all flags alone.
// [RULE2] A literal load takes its address from the word-aligned program counter plus an offset and leaves the flags alone.
// [RULE3] Word, halfword and byte stores use base plus register or immediate offset and leave the flags alone.
// [RULE4] The multiple store writes the listed registers to ascending addresses from the base and writes the final address back.
// [RULE5] Push and pop move a register list to and from the stack, adjust the stack pointer and leave the flags alone.
// [RULE6] Writing the status special register can update all four flags.
// [RULE7] Reading a special register copies its value and leaves the flags alone.
// [RULE8] The test instruction ANDs two registers, drops the result and updates only the negative and zero flags.
// [RULE9] Zero extension keeps the low byte or halfword and clears every higher bit, flags untouched.
// [RULE10] A program counter loaded by indirect branch, indirect branch with link or pop must have bit 0 set.
// [RULE11] A branch with link stores its return address with bit 0 forced to one.
// [RULE12] Only the single compact instruction set exists, so a target with bit 0 clear is a fault.
// [RULE13] The wait-for-event instruction is not implemented.
// [RULE14] A flag that an instruction does not update keeps its value.
// [RULE15] An access not aligned to its size raises a hard fault and is not performed.
`timescale 1ns/1ps
module cpu_ls_exec
  import cpu_ls_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic op_valid,
  input wire op_t op,
  output logic op_ready_r,
  output logic done_r,
  output logic fault_r,
  output logic unimpl_r,
  output logic mem_req_r,
  output logic mem_we_r,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata_r,
  output logic [3:0] mem_be_r,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output flags_t flags_r,
  output logic [31:0] pc_r,
  input wire logic [3:0] dbg_sel,
  output logic [31:0] dbg_val_r
);

  typedef enum {st_idle, st_exec, st_access, st_multi} state_t;

  state_t st_r, st_nxt;
  op_t cur_r;
  logic [31:0] regs_r [0:NUM_GPR-1];
  logic [15:0] rem_r, rem_nxt;
  logic [31:0] end_addr_r, end_nxt;
  logic primask_r;
  logic wa_en, wb_en, pc_we, pm_we, fin;
  logic [3:0] wa_idx, wb_idx, cur_idx, nxt_idx;
  logic [31:0] wa_val, wb_val, pc_val;
  logic [3:0] flag_we;
  flags_t flag_val;
  logic fault_ev, done_ev, unimpl_ev, issue, iss_we, acked;
  logic [31:0] iss_addr, iss_wdata;
  logic [3:0] iss_be;
  logic [31:0] base_w, offs_w, src_w, ea_w, tst_w, pc_seq, lane_addr;
  logic [31:0] list_bytes, multi_start, multi_end;
  logic [4:0] cnt_w [0:16];
  logic is_single, is_store, aligned_w;
  logic [3:0] lane_be;
  logic [31:0] lane_wdata, lane_load;
  size_t acc_size;

  function automatic logic [31:0] rd_reg(input logic [3:0] idx);
    rd_reg = (idx == REG_PC) ? pc_r : regs_r[idx];
  endfunction

  function automatic logic [3:0] lowest_set(input logic [15:0] m);
    lowest_set = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        lowest_set = 4'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand and address formation
  assign acked = mem_req_r && mem_ack;
  assign base_w = rd_reg(cur_r.rn);
  assign offs_w = cur_r.use_imm ? cur_r.imm : rd_reg(cur_r.rm);
  assign src_w = rd_reg(cur_r.rm);
  assign tst_w = rd_reg(cur_r.rn) & rd_reg(cur_r.rm); // RULE8
  assign pc_seq = pc_r + (cur_r.long_insn ? LONG_INSN : HALF_INSN);
  assign ea_w = (cur_r.opc == load_literal) // RULE2
              ? ((pc_r + PC_AHEAD) & WORD_MASK) + cur_r.imm
              : base_w + offs_w; // RULE3
  assign is_store = cur_r.opc inside {store_word, store_half, store_byte};
  assign is_single = is_store || cur_r.opc inside {load_word, load_half,
    load_byte, load_signed_byte, load_signed_half, load_literal};
  assign cur_idx = lowest_set(rem_r);

  // register-list length, one adder per list bit
  assign cnt_w[0] = 5'h00;
  for (genvar b = 0; b < 16; b++) begin : g_cnt
    assign cnt_w[b+1] = cnt_w[b] + {4'h0, cur_r.reglist[b]};
  end
  assign list_bytes = {25'h0, cnt_w[16], 2'b00};

  // push predecrements, multiple store and pop start at the base
  always_comb begin
    case (cur_r.opc)
      stack_push: multi_start = rd_reg(REG_SP) - list_bytes; // RULE5
      stack_pop: multi_start = rd_reg(REG_SP);
      default: multi_start = base_w; // RULE4
    endcase
    multi_end = (cur_r.opc == stack_push) ? multi_start
                                          : multi_start + list_bytes;
  end

  // access size and sign per opcode
  always_comb begin
    case (cur_r.opc)
      load_half, load_signed_half, store_half: acc_size = sz_half;
      load_byte, load_signed_byte, store_byte: acc_size = sz_byte;
      default: acc_size = sz_word;
    endcase
  end

  assign lane_addr = (st_r == st_exec) ? ea_w : mem_addr_r;

  mem_lane_unit u_lane (
    .addr(lane_addr),
    .size(acc_size),
    .sign_ext(cur_r.opc inside {load_signed_byte, load_signed_half}),
    .store_val(rd_reg(cur_r.rd)),
    .load_word(mem_rdata),
    .aligned(aligned_w),
    .byte_en(lane_be),
    .lane_wdata(lane_wdata),
    .load_val(lane_load)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and execution decisions
  always_comb begin
    st_nxt = st_r;
    rem_nxt = rem_r;
    end_nxt = end_addr_r;
    wa_en = 1'b0;
    wa_idx = cur_r.rd;
    wa_val = 32'h0;
    wb_en = 1'b0;
    wb_idx = REG_SP;
    wb_val = end_addr_r;
    pc_we = 1'b0;
    pc_val = pc_seq;
    flag_we = 4'h0;
    flag_val = flags_r;
    pm_we = 1'b0;
    fin = 1'b0;
    fault_ev = 1'b0;
    done_ev = 1'b0;
    unimpl_ev = 1'b0;
    issue = 1'b0;
    iss_addr = ea_w;
    iss_we = is_store;
    iss_wdata = lane_wdata;
    iss_be = lane_be;
    nxt_idx = 4'h0;
    case (st_r)
      st_idle: begin
        if (op_valid && op_ready_r) begin
          st_nxt = st_exec;
        end
      end
      st_exec: begin
        st_nxt = st_idle;
        fin = 1'b1;
        case (cur_r.opc)
          load_word, load_half, load_byte, load_signed_byte,
          load_signed_half, load_literal, store_word, store_half,
          store_byte: begin
            fin = 1'b0;
            if (!aligned_w) begin
              fault_ev = 1'b1; // RULE15
            end else begin
              issue = 1'b1;
              st_nxt = st_access;
            end
          end
          store_multiple_inc_after, stack_push, stack_pop: begin
            rem_nxt = cur_r.reglist;
            end_nxt = multi_end;
            iss_addr = multi_start;
            iss_we = cur_r.opc != stack_pop;
            iss_wdata = rd_reg(lowest_set(cur_r.reglist));
            iss_be = BE_WORD;
            if (multi_start[1:0] != 2'b00) begin
              fin = 1'b0;
              fault_ev = 1'b1; // RULE15
            end else if (cur_r.reglist != 16'h0) begin
              fin = 1'b0;
              issue = 1'b1;
              st_nxt = st_multi;
            end
          end
          write_special_from_general: begin
            case (cur_r.spec)
              spec_apsr: begin
                flag_we = FLAG_WE_ALL; // RULE6
                flag_val = src_w[FLAG_MSB:FLAG_LSB];
              end
              spec_primask: pm_we = 1'b1;
              default: begin
                wa_en = 1'b1;
                wa_idx = REG_SP;
                wa_val = src_w & WORD_MASK;
              end
            endcase
          end
          read_special_to_general: begin
            wa_en = 1'b1; // RULE7
            case (cur_r.spec)
              spec_apsr: wa_val = {flags_r, 28'h0000000};
              spec_primask: wa_val = {31'h0, primask_r};
              default: wa_val = rd_reg(REG_SP);
            endcase
          end
          and_test_flags: begin
            flag_we = FLAG_WE_NZ; // RULE8
            flag_val.n = tst_w[31];
            flag_val.z = tst_w == 32'h0;
          end
          zero_extend_byte: begin
            wa_en = 1'b1;
            wa_val = {24'h000000, src_w[7:0]}; // RULE9
          end
          zero_extend_half: begin
            wa_en = 1'b1;
            wa_val = {16'h0000, src_w[15:0]}; // RULE9
          end
          indirect_branch, indirect_branch_link: begin
            if (!src_w[0]) begin
              fin = 1'b0;
              fault_ev = 1'b1; // RULE10 RULE12
            end else begin
              pc_val = src_w & ISA_BIT_CLR;
              wa_en = cur_r.opc == indirect_branch_link;
              wa_idx = REG_LR;
              wa_val = pc_seq | ISA_BIT; // RULE11
            end
          end
          branch_link: begin
            pc_val = (pc_r + PC_AHEAD + cur_r.imm) & ISA_BIT_CLR;
            wa_en = 1'b1;
            wa_idx = REG_LR;
            wa_val = pc_seq | ISA_BIT; // RULE11
          end
          wait_for_event_op: unimpl_ev = 1'b1; // RULE13
          no_op: fin = 1'b1;
          default: begin
            fin = 1'b0;
            fault_ev = 1'b1;
          end
        endcase
        if (fin) begin
          done_ev = 1'b1;
          pc_we = 1'b1;
        end
      end
      st_access: begin
        if (acked) begin
          st_nxt = st_idle;
          done_ev = 1'b1;
          pc_we = 1'b1;
          wa_en = !mem_we_r; // RULE1
          wa_val = lane_load;
        end
      end
      st_multi: begin
        if (acked) begin
          rem_nxt = rem_r & ~(16'h0001 << cur_idx);
          nxt_idx = lowest_set(rem_nxt);
          if (!mem_we_r && cur_idx != REG_PC) begin
            wa_en = 1'b1; // RULE5
            wa_idx = cur_idx;
            wa_val = mem_rdata;
          end
          if (!mem_we_r && cur_idx == REG_PC && !mem_rdata[0]) begin
            st_nxt = st_idle;
            fault_ev = 1'b1; // RULE10 RULE12
          end else if (rem_nxt == 16'h0) begin
            st_nxt = st_idle;
            done_ev = 1'b1;
            wb_en = 1'b1; // RULE4 RULE5
            wb_idx = (cur_r.opc == store_multiple_inc_after) ? cur_r.rn
                                                             : REG_SP;
            pc_we = 1'b1;
            if (!mem_we_r && cur_idx == REG_PC) begin
              pc_val = mem_rdata & ISA_BIT_CLR; // RULE10
            end
          end else begin
            issue = 1'b1;
            iss_addr = mem_addr_r + WORD_BYTES; // RULE4
            iss_we = mem_we_r;
            iss_wdata = rd_reg(nxt_idx);
            iss_be = BE_WORD;
          end
        end
      end
      default: st_nxt = st_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, held operation and list progress
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= st_idle;
      cur_r <= '0;
      rem_r <= 16'h0;
      end_addr_r <= 32'h0;
    end else if (ce) begin
      st_r <= st_nxt;
      rem_r <= rem_nxt;
      end_addr_r <= end_nxt;
      if (st_r == st_idle && op_valid && op_ready_r) begin
        cur_r <= op;
      end
    end
  end

  // general registers, one write port with priority and one writeback port
  for (genvar g = 0; g < NUM_GPR; g++) begin : g_reg
    always_ff @(posedge mclk) begin
      if (rst) begin
        regs_r[g] <= GPR_RST;
      end else if (ce) begin
        if (wa_en && wa_idx == 4'(g)) begin
          regs_r[g] <= wa_val;
        end else if (wb_en && wb_idx == 4'(g)) begin
          regs_r[g] <= wb_val;
        end
      end
    end
  end

  // program counter and interrupt mask bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_r <= PC_RST;
      primask_r <= PRIMASK_RST;
    end else if (ce) begin
      if (pc_we) begin
        pc_r <= pc_val;
      end
      if (pm_we) begin
        primask_r <= src_w[0];
      end
    end
  end

  // condition flags, each written only when selected
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_r <= FLAGS_RST;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (flag_we[i]) begin
          flags_r[i] <= flag_val[i]; // RULE14
        end
      end
    end
  end

  // memory request held until acknowledged
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 32'h0;
      mem_wdata_r <= 32'h0;
      mem_be_r <= 4'h0;
    end else if (ce) begin
      if (issue) begin
        mem_req_r <= 1'b1;
        mem_we_r <= iss_we;
        mem_addr_r <= iss_addr;
        mem_wdata_r <= iss_wdata;
        mem_be_r <= iss_be;
      end else if (acked) begin
        mem_req_r <= 1'b0;
      end
    end
  end

  // status pulses, ready and debug readback
  always_ff @(posedge mclk) begin
    if (rst) begin
      op_ready_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      unimpl_r <= 1'b0;
      dbg_val_r <= 32'h0;
    end else if (ce) begin
      op_ready_r <= st_nxt == st_idle;
      done_r <= done_ev;
      fault_r <= fault_ev;
      unimpl_r <= unimpl_ev;
      dbg_val_r <= rd_reg(dbg_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_load_flags_hold: assert property (@(posedge mclk) disable iff (rst) // RULE1
    ce && st_r == st_access && acked && !mem_we_r |=> $stable(flags_r))
    else $error("load changed flags");
  chk_literal_word: assert property (@(posedge mclk) disable iff (rst) // RULE2
    ce && st_r == st_exec && cur_r.opc == load_literal && !fault_ev
    |=> mem_req_r && !mem_we_r && mem_addr_r[1:0] == 2'b00)
    else $error("literal load address not word aligned");
  chk_store_flags_hold: assert property (@(posedge mclk) disable iff (rst) // RULE3
    ce && st_r == st_access && acked && mem_we_r |=> $stable(flags_r))
    else $error("store changed flags");
  chk_multi_ascend: assert property (@(posedge mclk) disable iff (rst) // RULE4
    ce && st_r == st_multi && acked && st_nxt == st_multi
    |=> mem_req_r && mem_addr_r == $past(mem_addr_r) + WORD_BYTES)
    else $error("multiple transfer address not ascending");
  chk_special_flags: assert property (@(posedge mclk) disable iff (rst) // RULE6
    ce && st_r == st_exec && cur_r.opc == write_special_from_general
    && cur_r.spec == spec_apsr |=> flags_r == $past(src_w[31:28]))
    else $error("status write did not load flags");
  chk_test_only_nz: assert property (@(posedge mclk) disable iff (rst) // RULE8
    ce && st_r == st_exec && cur_r.opc == and_test_flags
    |=> flags_r.c == $past(flags_r.c) && flags_r.v == $past(flags_r.v)
    && flags_r.z == ($past(tst_w) == 32'h0) && flags_r.n == $past(tst_w[31]))
    else $error("test flags wrong");
  chk_branch_bit0: assert property (@(posedge mclk) disable iff (rst) // RULE10
    ce && st_r == st_exec && cur_r.opc == indirect_branch && !src_w[0]
    |=> fault_r && $stable(pc_r))
    else $error("bad branch target not faulted");
  chk_link_bit: assert property (@(posedge mclk) disable iff (rst) // RULE11
    ce && st_r == st_exec && cur_r.opc == branch_link
    |=> regs_r[REG_LR] == ($past(pc_seq) | ISA_BIT))
    else $error("link value wrong");
  chk_unaligned_fault: assert property (@(posedge mclk) disable iff (rst) // RULE15
    ce && st_r == st_exec && is_single && !aligned_w
    |=> fault_r && !mem_req_r ##1 !done_r)
    else $error("unaligned access not faulted");

endmodule

// >>> sim/data_mem_model.sv
// data memory model that answers the execution unit's memory requests
`timescale 1ns/1ps
module data_mem_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic mem_req_r,
  input wire logic mem_we_r,
  input wire logic [31:0] mem_addr_r,
  input wire logic [31:0] mem_wdata_r,
  input wire logic [3:0] mem_be_r,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [64];
  logic [31:0] last_r;
  logic [1:0] dly_r;
  wire [5:0] idx = mem_addr_r[7:2];
  ////////////////////////////////////////////////////////////////////////////
  // even words carry bit 0 set so they serve as legal branch targets
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'h96, 8'(i), 8'h40, 8'(i) ^ 8'h01};
    end
    mem_ack = 1'b0;
    last_r = 32'h0000_0000;
    dly_r = 2'h0;
  end
  // data is only valid with ack; between answers the bus shows a changed word
  assign mem_rdata = mem_ack ? mem[idx] : ~last_r;
  // one ack per request, after a three-cycle stall when slow
  always @(posedge mclk) begin
    if (mem_req_r && mem_ack) begin
      last_r <= mem[idx];
      for (int k = 0; k < 4; k++) begin
        if (mem_we_r && mem_be_r[k]) mem[idx][8*k+:8] <= mem_wdata_r[8*k+:8];
      end
    end
    mem_ack <= mem_req_r && !mem_ack && (!slow || dly_r == 2'h3);
    dly_r <= (mem_req_r && !mem_ack) ? dly_r + 2'h1 : 2'h0;
  end
endmodule

// >>> sim/cpu_load_store_misc_decode_test.sv
// self-checking testbench for the load/store and misc execution unit
`timescale 1ns/1ps
module cpu_load_store_misc_decode_test;
  import cpu_ls_pkg::*;
  typedef struct packed {op_t o; logic [31:0] e;} row_t;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, op_valid = 1'b0, slow = 1'b0;
  op_t op = '0;
  logic op_ready_r, done_r, fault_r, unimpl_r, mem_req_r, mem_we_r, mem_ack;
  logic [31:0] mem_addr_r, mem_wdata_r, mem_rdata, pc_r, dbg_val_r;
  logic [3:0] mem_be_r;
  logic [3:0] dbg_sel = 4'h0;
  flags_t flags_r;
  int n_fail = 0, checks_done = 0;
  logic [31:0] exp_pc = 32'h0000_0000, v;
  logic [3:0] exp_fl = 4'h0;
  logic got_u;
  row_t rows [8];
  always #2.5 mclk = ~mclk;
  cpu_ls_exec i_cpu_ls_exec (.mclk(mclk), .rst(rst), .ce(ce),
    .op_valid(op_valid), .op(op), .op_ready_r(op_ready_r), .done_r(done_r),
    .fault_r(fault_r), .unimpl_r(unimpl_r), .mem_req_r(mem_req_r),
    .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
    .mem_be_r(mem_be_r), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .flags_r(flags_r), .pc_r(pc_r), .dbg_sel(dbg_sel), .dbg_val_r(dbg_val_r));
  data_mem_model i_data_mem_model (.mclk(mclk), .slow(slow),
    .mem_req_r(mem_req_r), .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r),
    .mem_wdata_r(mem_wdata_r), .mem_be_r(mem_be_r), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  ////////////////////////////////////////////////////////////////////////////
  // helpers: operation builder, compare, register read, operation runner
  function automatic op_t mk(opc_t c, logic [3:0] d, logic [3:0] n,
      logic [3:0] m, logic ui, logic [31:0] im, logic [15:0] rl);
    op_t o;
    o = '0;
    o.opc = c;
    o.rd = d;
    o.rn = n;
    o.rm = m;
    o.use_imm = ui;
    o.imm = im;
    o.reglist = rl;
    o.spec = spec_apsr;
    return o;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(logic [3:0] idx, output logic [31:0] val);
    @(posedge mclk);
    dbg_sel <= idx;
    @(posedge mclk);
    @(posedge mclk);
    #1 val = dbg_val_r;
  endtask
  // offer one operation, wait for its pulse, check fault, flags and pc
  task automatic run_op(op_t o, logic ef, logic [31:0] tgt);
    logic f;
    f = 1'b0;
    got_u = 1'b0;
    for (int n = 0; n < 50 && op_ready_r !== 1'b1; n++) @(negedge mclk);
    chk({31'h0, op_ready_r}, 32'h0000_0001);
    @(posedge mclk);
    op_valid <= 1'b1;
    op <= o;
    @(posedge mclk);
    op_valid <= 1'b0;
    for (int n = 0; n < 80; n++) begin
      @(negedge mclk);
      got_u = unimpl_r === 1'b1;
      if (done_r === 1'b1 || fault_r === 1'b1) break;
      if (n == 79) chk({31'h0, done_r}, 32'h0000_0001);
    end
    f = fault_r;
    if (!ef) exp_pc = (tgt != 0) ? tgt : exp_pc + (o.long_insn ? 4 : 2);
    chk({31'h0, f}, {31'h0, ef});
    chk({28'h0, flags_r}, {28'h0, exp_fl});
    chk(pc_r, exp_pc);
  endtask
  task automatic print_verdict();
    $display("fails=%0d checks=%0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #(5 * 20000);
    n_fail++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    op_t o;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    chk(pc_r, PC_RST);
    chk({28'h0, flags_r}, {28'h0, FLAGS_RST});
    run_op(mk(load_word, 4'hc, 4'h0, 4'h0, 1'b1, 32'h0, 16'h0), 0, 0);
    exp_fl = 4'h9;
    run_op(mk(write_special_from_general, 4'h0, 4'h0, 4'hc, 1'b0, 0, 0),
      0, 0);
    rows[0] = '{mk(load_word, 4'h1, 4'h0, 4'h0, 1, 8, 0), 32'h9602_4003};
    rows[1] = '{mk(load_half, 4'h2, 4'h0, 4'h0, 1, 6, 0), 32'h0000_9601};
    rows[2] = '{mk(load_byte, 4'h3, 4'h0, 4'h0, 1, 5, 0), 32'h0000_0040};
    rows[3] = '{mk(load_signed_byte, 4'h4, 4'h0, 4'h0, 1, 7, 0), 32'hffff_ff96};
    rows[4] = '{mk(load_signed_half, 4'h5, 4'h0, 4'h0, 1, 10, 0), 32'hffff_9602};
    rows[5] = '{mk(zero_extend_byte, 4'h6, 4'h0, 4'h5, 0, 0, 0), 32'h0000_0002};
    rows[6] = '{mk(zero_extend_half, 4'h7, 4'h0, 4'h5, 0, 0, 0), 32'h0000_9602};
    rows[7] = '{mk(read_special_to_general, 4'h8, 0, 0, 0, 0, 0), 32'h9000_0000};
    for (int r = 0; r < 8; r++) begin
      run_op(rows[r].o, 0, 0);
      rd_reg(rows[r].o.rd, v);
      chk(v, rows[r].e);
    end
    run_op(mk(read_special_to_general, 4'h8, 0, 0, 0, 0, 0), 0, 0);
    exp_fl = 4'h5;
    run_op(mk(and_test_flags, 4'h0, 4'hc, 4'h6, 0, 0, 0), 0, 0);
    run_op(mk(load_half, 4'h2, 4'h0, 4'h0, 1, 1, 0), 1, 0);
    run_op(mk(store_byte, 4'h4, 4'h0, 4'h0, 1, 32'h81, 0), 0, 0);
    run_op(mk(store_half, 4'h5, 4'h0, 4'h0, 1, 32'h86, 0), 0, 0);
    run_op(mk(store_word, 4'h1, 4'h0, 4'h6, 0, 0, 0), 1, 0);
    run_op(mk(store_word, 4'h1, 4'h3, 4'h0, 1, 32'h30, 0), 0, 0);
    chk(i_data_mem_model.mem[32], 32'h9620_9621);
    chk(i_data_mem_model.mem[33], 32'h9602_4020);
    chk(i_data_mem_model.mem[28], 32'h9602_4003);
    slow <= 1'b1;
    run_op(mk(store_multiple_inc_after, 0, 4'h3, 0, 0, 0, 16'h0016), 0, 0);
    chk(i_data_mem_model.mem[16], 32'h9602_4003);
    chk(i_data_mem_model.mem[17], 32'h0000_9601);
    chk(i_data_mem_model.mem[18], 32'hffff_ff96);
    rd_reg(4'h3, v);
    chk(v, 32'h0000_004c);
    run_op(mk(stack_push, 0, 0, 0, 0, 0, 16'h0006), 0, 0);
    rd_reg(REG_SP, v);
    chk(v, 32'hffff_fff8);
    chk(i_data_mem_model.mem[63], 32'h0000_9601);
    slow <= 1'b0;
    run_op(mk(stack_pop, 0, 0, 0, 0, 0, 16'h8800), 0, 32'h9600);
    rd_reg(4'hb, v);
    chk(v, 32'h9602_4003);
    rd_reg(REG_SP, v);
    chk(v, 32'h0000_0000);
    o = mk(branch_link, 0, 0, 0, 1, 32'h10, 0);
    o.long_insn = 1'b1;
    run_op(o, 0, 32'h9614);
    rd_reg(REG_LR, v);
    chk(v, 32'h0000_9605);
    run_op(mk(indirect_branch_link, 0, 0, 4'h2, 0, 0, 0), 0, 32'h9600);
    rd_reg(REG_LR, v);
    chk(v, 32'h0000_9617);
    run_op(mk(indirect_branch, 0, 0, 4'h6, 0, 0, 0), 1, 0);
    run_op(mk(load_literal, 4'h9, 0, 0, 1, 8, 0), 0, 0);
    rd_reg(4'h9, v);
    chk(v, 32'h9603_4002);
    run_op(mk(stack_push, 0, 0, 0, 0, 0, 16'h0040), 0, 0);
    run_op(mk(stack_pop, 0, 0, 0, 0, 0, 16'h8000), 1, 0);
    run_op(mk(wait_for_event_op, 0, 0, 0, 0, 0, 0), 0, 0);
    chk({31'h0, got_u}, 32'h0000_0001);
    // interrupt mask and stack pointer as special registers
    o = mk(write_special_from_general, 0, 0, 4'hc, 0, 0, 0);
    o.spec = spec_primask;
    run_op(o, 0, 0);
    o.opc = read_special_to_general;
    o.rd = 4'ha;
    run_op(o, 0, 0);
    rd_reg(4'ha, v);
    chk(v, 32'h0000_0001);
    o.opc = write_special_from_general;
    o.spec = spec_msp;
    o.rm = 4'h1;
    run_op(o, 0, 0);
    rd_reg(REG_SP, v);
    chk(v, 32'h9602_4000);
    // clock enable low: an offered operation is not taken
    @(posedge mclk);
    ce <= 1'b0;
    op_valid <= 1'b1;
    op <= mk(no_op, 0, 0, 0, 0, 0, 0);
    repeat (4) @(posedge mclk);
    op_valid <= 1'b0;
    ce <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(pc_r, exp_pc);
    run_op(mk(no_op, 0, 0, 0, 0, 0, 0), 0, 0);
    // mid-run reset: pc, flags and registers back to reset values
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    exp_pc = PC_RST;
    exp_fl = FLAGS_RST;
    @(negedge mclk);
    chk({31'h0, op_ready_r}, 32'h0000_0000);
    rd_reg(4'hc, v);
    chk(v, GPR_RST);
    run_op(mk(no_op, 0, 0, 0, 0, 0, 0), 0, 0);
    print_verdict();
  end
endmodule
